// ---- hw/hsr_pkg.sv ----
// Constants, field layouts and carrier types of the live-insertion controller status register bank
package hsr_pkg;

    // Register indices; only the low address bits select a register
    localparam int ADDR_SEL_W = 3;
    localparam logic [ADDR_SEL_W-1:0] REG_SYSTEM_STATUS = 3'h2;
    localparam logic [ADDR_SEL_W-1:0] REG_FAULT_LOG = 3'h3;
    localparam logic [ADDR_SEL_W-1:0] REG_CURRENT_SENSE = 3'h4;
    localparam logic [ADDR_SEL_W-1:0] REG_OUTPUT_VOLTAGE = 3'h5;
    localparam logic [ADDR_SEL_W-1:0] REG_AUX_INPUT = 3'h6;

    // System status bit positions
    localparam int ST_FET_ON = 7;
    localparam int ST_GPIO_LEVEL = 6;
    localparam int ST_FET_SHORT = 5;
    localparam int ST_BOARD_PRESENT = 4;
    localparam int ST_POWER_BAD = 3;
    localparam int ST_OVERCURRENT = 2;
    localparam int ST_UNDERVOLTAGE = 1;
    localparam int ST_OVERVOLTAGE = 0;

    // Fault log bit positions; bits 7:6 reserved
    localparam int FAULT_W = 6;
    localparam int FL_FET_SHORT = 5;
    localparam int FL_BOARD_CHANGE = 4;
    localparam int FL_POWER_BAD = 3;
    localparam int FL_OVERCURRENT = 2;
    localparam int FL_UNDERVOLTAGE = 1;
    localparam int FL_OVERVOLTAGE = 0;

    // Reset values
    localparam logic [FAULT_W-1:0] FAULT_RESET = 6'h00;
    localparam logic [7:0] SAMPLE_RESET = 8'h00;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ADC scaling
    localparam int SENSE_LSB_UV = 300;
    localparam int SENSE_FULL_SCALE_UV = 76800;
    localparam int OUTPUT_LSB_MV = 400;
    localparam int OUTPUT_FULL_SCALE_MV = 102400;
    localparam int AUX_LSB_MV = 10;
    localparam int AUX_FULL_SCALE_MV = 2560;
    localparam int SHORT_THRESH_UV = 2000;
    // Code strictly above this means more than the threshold voltage
    localparam logic [7:0] SHORT_THRESH_CODE = 8'(SHORT_THRESH_UV / SENSE_LSB_UV);

    // ADC channel codes
    localparam logic [1:0] CH_CURRENT_SENSE = 2'h0;
    localparam logic [1:0] CH_OUTPUT_VOLTAGE = 2'h1;
    localparam logic [1:0] CH_AUX_INPUT = 2'h2;

    // Timing
    localparam int CLOCK_PERIOD_PS = 25000;
    localparam int CONV_INTERVAL_NS = 10000;
    localparam int CONV_INTERVAL_CYC = (CONV_INTERVAL_NS * 1000) / CLOCK_PERIOD_PS;
    localparam int CONV_DIV_W = 9;
    localparam logic [CONV_DIV_W-1:0] CONV_DIV_LAST = CONV_DIV_W'(CONV_INTERVAL_CYC - 1);
    // Edges after reset before logging: two synchroniser stages plus one level load
    localparam logic [1:0] ARM_LAST = 2'h3;

    typedef enum logic [0:0] {CONV_WAIT, CONV_BUSY} hsr_conv_state_t;

    // Condition inputs, all from outside the clock domain
    typedef struct packed {
        logic fet_on;
        logic gpio_level;
        logic board_present_pin;
        logic power_good_feedback;
        logic undervoltage_input;
        logic overvoltage_input;
        logic oc_cooldown;
    } hsr_pins_t;

    localparam int PIN_W = $bits(hsr_pins_t);

    // Levels kept to find the edges that log faults
    typedef struct packed {
        logic fet_short;
        logic board_present_pin;
        logic power_good_feedback;
        logic undervoltage_input;
        logic overvoltage_input;
        logic oc_cooldown;
    } hsr_levels_t;

    // Register access from the serial engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hsr_reg_req_t;

endpackage

// ---- hw/hsr_sync.sv ----
// Two-flop synchroniser for a vector of independent levels
module hsr_sync #(
    parameter int W = 1
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [W-1:0] d, // Asynchronous levels
    output logic [W-1:0] q // Synchronised levels
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } hsr_sync_st_t;

    hsr_sync_st_t st_r;
    hsr_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.meta = d;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.stable;
endmodule // hsr_sync

// ---- hw/hsr_sample_reg.sv ----
// One ADC result register, loaded by conversions or by the host in test mode
module hsr_sample_reg (
    input wire logic clock, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic host_wr, // Qualified host write
    input wire logic [7:0] host_data, // Host write data
    input wire logic conv_load, // Qualified conversion result
    input wire logic [7:0] conv_data, // Conversion code
    output logic [7:0] value // Stored code
);
    import hsr_pkg::*;

    typedef struct packed {
        logic [7:0] value;
    } hsr_sample_st_t;

    hsr_sample_st_t st_r;
    hsr_sample_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (host_wr)
        begin
            st_nxt.value = host_data;
        end
        else if (conv_load)
        begin
            st_nxt.value = conv_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r.value <= SAMPLE_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign value = st_r.value;
endmodule // hsr_sample_reg

// ---- hw/hsr_regs.sv ----
// Status, fault log and ADC result register bank of the live-insertion power controller
module hsr_regs (
    input wire logic CLOCK, // System clock, 40 MHz
    input wire logic RST_N, // Asynchronous reset, active low
    input wire hsr_pkg::hsr_pins_t HSR_PINS, // Condition pins, asynchronous
    input wire hsr_pkg::hsr_reg_req_t REG_REQ, // Register access from serial engine
    output logic [7:0] RD_DATA, // Read data, registered
    output logic RD_VALID, // Read data valid pulse
    output logic RD_HIT, // Read address belongs to this bank
    input wire logic TEST_MODE_BIT, // Test mode from control register
    input wire logic [5:0] ALERT_ENABLE, // Alert enables from alert register
    output logic ALERT_O, // Alert pin output level, always low
    output logic ALERT_OE, // Alert pin pull-down enable
    output logic ADC_START, // Start one conversion, pulse
    output logic [1:0] ADC_CHANNEL, // Channel of the conversion
    input wire logic ADC_DONE, // Conversion finished, pulse
    input wire logic [7:0] ADC_RESULT // Conversion code
);
    import hsr_pkg::*;

    typedef struct packed {
        logic [1:0] arm;
        hsr_levels_t prev;
        logic [FAULT_W-1:0] fault;
        logic alert;
        logic [7:0] rd_data;
        logic rd_valid;
        logic rd_hit;
        hsr_conv_state_t conv;
        logic [CONV_DIV_W-1:0] div;
        logic [1:0] chan;
        logic adc_start;
    } hsr_top_st_t;

    hsr_top_st_t st_r;
    hsr_top_st_t st_nxt;

    logic [PIN_W-1:0] pin_sync_q;
    hsr_pins_t pins;
    hsr_levels_t now;
    logic [7:0] status;
    logic [FAULT_W-1:0] events;
    logic [FAULT_W-1:0] fault_base;
    logic [ADDR_SEL_W-1:0] sel;
    logic host_wr_sense;
    logic host_wr_output;
    logic host_wr_aux;
    logic conv_result;
    logic [7:0] sense_code;
    logic [7:0] output_code;
    logic [7:0] aux_code;

    hsr_sync #(
        .W(PIN_W)
    ) u_pin_sync (
        .clock(CLOCK),
        .rst_n(RST_N),
        .d(PIN_W'(HSR_PINS)),
        .q(pin_sync_q)
    );

    assign pins = hsr_pins_t'(pin_sync_q);

    // Register select from low address bits only
    // low bits decode
    assign sel = REG_REQ.addr[ADDR_SEL_W-1:0];

    // Result writes gated by test mode
    // test mode gate
    assign host_wr_sense = REG_REQ.wr && TEST_MODE_BIT && (sel == REG_CURRENT_SENSE);
    assign host_wr_output = REG_REQ.wr && TEST_MODE_BIT && (sel == REG_OUTPUT_VOLTAGE);
    assign host_wr_aux = REG_REQ.wr && TEST_MODE_BIT && (sel == REG_AUX_INPUT);

    // Result lost if test mode comes on mid-conversion
    // halt discards results
    assign conv_result = (st_r.conv == CONV_BUSY) && ADC_DONE && !TEST_MODE_BIT;

    hsr_sample_reg u_current_sense_sample (
        .clock(CLOCK),
        .rst_n(RST_N),
        .host_wr(host_wr_sense),
        .host_data(REG_REQ.wdata),
        .conv_load(conv_result && (st_r.chan == CH_CURRENT_SENSE)),
        .conv_data(ADC_RESULT),
        .value(sense_code)
    );

    hsr_sample_reg u_output_voltage_sample (
        .clock(CLOCK),
        .rst_n(RST_N),
        .host_wr(host_wr_output),
        .host_data(REG_REQ.wdata),
        .conv_load(conv_result && (st_r.chan == CH_OUTPUT_VOLTAGE)),
        .conv_data(ADC_RESULT),
        .value(output_code)
    );

    hsr_sample_reg u_aux_input_sample (
        .clock(CLOCK),
        .rst_n(RST_N),
        .host_wr(host_wr_aux),
        .host_data(REG_REQ.wdata),
        .conv_load(conv_result && (st_r.chan == CH_AUX_INPUT)),
        .conv_data(ADC_RESULT),
        .value(aux_code)
    );

    // Present levels, shared by status and edge logging
    always_comb
    begin
        now = '0;
        now.fet_short = !pins.fet_on && (sense_code > SHORT_THRESH_CODE);
        now.board_present_pin = pins.board_present_pin;
        now.power_good_feedback = pins.power_good_feedback;
        now.undervoltage_input = pins.undervoltage_input;
        now.overvoltage_input = pins.overvoltage_input;
        now.oc_cooldown = pins.oc_cooldown;
    end

    // Live status word
    always_comb
    begin
        status = 8'h00;
        status[ST_FET_ON] = pins.fet_on;
        status[ST_GPIO_LEVEL] = pins.gpio_level;
        status[ST_FET_SHORT] = now.fet_short;
        status[ST_BOARD_PRESENT] = !pins.board_present_pin;
        status[ST_POWER_BAD] = !pins.power_good_feedback;
        status[ST_OVERCURRENT] = pins.oc_cooldown;
        status[ST_UNDERVOLTAGE] = !pins.undervoltage_input;
        status[ST_OVERVOLTAGE] = pins.overvoltage_input;
    end

    // Edge events; held off until real pin levels have reached prev
    // Synchroniser resets to zero, so a high pin would otherwise log a false edge
    always_comb
    begin
        events = '0;
        if (st_r.arm == ARM_LAST)
        begin
            events[FL_FET_SHORT] = now.fet_short && !st_r.prev.fet_short;
            events[FL_BOARD_CHANGE] = now.board_present_pin != st_r.prev.board_present_pin;
            events[FL_POWER_BAD] = !now.power_good_feedback && st_r.prev.power_good_feedback;
            events[FL_OVERCURRENT] = now.oc_cooldown && !st_r.prev.oc_cooldown;
            events[FL_UNDERVOLTAGE] = !now.undervoltage_input && st_r.prev.undervoltage_input;
            events[FL_OVERVOLTAGE] = now.overvoltage_input && !st_r.prev.overvoltage_input;
        end
    end

    // Host write replaces the log; new events are ORed on top so they win
    always_comb
    begin
        fault_base = st_r.fault;
        if (REG_REQ.wr && (sel == REG_FAULT_LOG))
        begin
            fault_base = REG_REQ.wdata[FAULT_W-1:0];
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        if (st_r.arm != ARM_LAST)
        begin
            st_nxt.arm = st_r.arm + 2'h1;
        end
        st_nxt.prev = now;
        st_nxt.adc_start = 1'b0;
        st_nxt.rd_valid = 1'b0;

        st_nxt.fault = fault_base | events;

        st_nxt.alert = |(st_nxt.fault & ALERT_ENABLE);

        // Read snapshot; writes to status fall through unused
        // status read only
        if (REG_REQ.rd)
        begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_hit = 1'b1;
            case (sel)
                REG_SYSTEM_STATUS: st_nxt.rd_data = status;
                REG_FAULT_LOG: st_nxt.rd_data = {{(8 - FAULT_W){1'b0}}, st_r.fault};
                REG_CURRENT_SENSE: st_nxt.rd_data = sense_code;
                REG_OUTPUT_VOLTAGE: st_nxt.rd_data = output_code;
                REG_AUX_INPUT: st_nxt.rd_data = aux_code;
                default:
                begin
                    st_nxt.rd_data = UNMAPPED_READ;
                    st_nxt.rd_hit = 1'b0;
                end
            endcase
        end

        // Free-running conversion sequencer over the three channels
        // self-timed refresh
        case (st_r.conv)
            CONV_WAIT:
            begin
                // Divider parked, so the first result after test mode is a full interval away
                if (TEST_MODE_BIT)
                begin
                    st_nxt.div = '0;
                end
                else if (st_r.div == CONV_DIV_LAST)
                begin
                    st_nxt.div = '0;
                    st_nxt.adc_start = 1'b1;
                    st_nxt.conv = CONV_BUSY;
                end
                else
                begin
                    st_nxt.div = st_r.div + 1'b1;
                end
            end
            CONV_BUSY:
            begin
                // Channel advances even for a discarded result, keeping the order fixed
                if (ADC_DONE)
                begin
                    st_nxt.conv = CONV_WAIT;
                    if (st_r.chan == CH_AUX_INPUT)
                    begin
                        st_nxt.chan = CH_CURRENT_SENSE;
                    end
                    else
                    begin
                        st_nxt.chan = st_r.chan + 1'b1;
                    end
                end
            end
            default:
            begin
                st_nxt.conv = CONV_WAIT;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_r.arm <= 2'h0;
            st_r.prev <= '0;
            st_r.fault <= FAULT_RESET;
            st_r.alert <= 1'b0;
            st_r.rd_data <= READ_DATA_RESET;
            st_r.rd_valid <= 1'b0;
            st_r.rd_hit <= 1'b0;
            st_r.conv <= CONV_WAIT;
            st_r.div <= '0;
            st_r.chan <= CH_CURRENT_SENSE;
            st_r.adc_start <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign RD_DATA = st_r.rd_data;
    assign RD_VALID = st_r.rd_valid;
    assign RD_HIT = st_r.rd_hit;
    // Open drain: only ever pulls low
    assign ALERT_O = 1'b0;
    assign ALERT_OE = st_r.alert;
    assign ADC_START = st_r.adc_start;
    assign ADC_CHANNEL = st_r.chan;
endmodule // hsr_regs

// ---- tb/hsr_adc_model.sv ----
// Behavioural converter that answers start pulses with scaled codes
module hsr_adc_model (
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic adc_start, // Start pulse
    input wire logic [1:0] adc_channel, // Channel to convert
    output logic adc_done, // Done pulse
    output logic [7:0] adc_result, // Code, valid with done only
    input wire logic [31:0] sense_uv, // Sense voltage, microvolts
    input wire logic [31:0] out_mv, // Output voltage, millivolts
    input wire logic [31:0] aux_mv // Auxiliary voltage, millivolts
);
    import hsr_pkg::*;
    logic busy_r;
    logic slow_r;
    logic [5:0] cnt_r;
    logic [1:0] ch_r;

    function automatic logic [7:0] to_code(input logic [31:0] v, input logic [31:0] lsb);
        return (v / lsb > 32'hff) ? 8'hff : 8'(v / lsb);
    endfunction

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            slow_r <= 1'b0;
            cnt_r <= 6'h00;
            ch_r <= 2'h0;
            adc_done <= 1'b0;
            adc_result <= 8'h00;
        end
        else
        begin
            adc_done <= 1'b0;
            // Stale data toggles so it never passes for a result
            adc_result <= ~adc_result;
            if (adc_start)
            begin
                busy_r <= 1'b1;
                ch_r <= adc_channel;
                // Alternate prompt and slow answers
                cnt_r <= slow_r ? 6'h25 : 6'h01;
                slow_r <= ~slow_r;
            end
            else if (busy_r && cnt_r == 6'h00)
            begin
                busy_r <= 1'b0;
                adc_done <= 1'b1;
                adc_result <= (ch_r == 2'h0) ? to_code(sense_uv, SENSE_LSB_UV) :
                    (ch_r == 2'h1) ? to_code(out_mv, OUTPUT_LSB_MV) : to_code(aux_mv, AUX_LSB_MV);
            end
            else if (busy_r)
            begin
                cnt_r <= cnt_r - 6'h01;
            end
        end
    end
endmodule // hsr_adc_model

// ---- tb/hsr_regs_assertions.sv ----
// Port-level checks of the live-insertion controller status register bank
module hsr_regs_assertions (
    input wire logic CLOCK, // System clock
    input wire logic RST_N, // Async reset, active low
    input wire hsr_pkg::hsr_pins_t HSR_PINS, // Condition pins
    input wire hsr_pkg::hsr_reg_req_t REG_REQ, // Register access
    input wire logic [7:0] RD_DATA, // Read data
    input wire logic RD_VALID, // Read valid
    input wire logic RD_HIT, // Address hit
    input wire logic TEST_MODE_BIT, // Test mode
    input wire logic [5:0] ALERT_ENABLE, // Alert enables
    input wire logic ALERT_OE, // Alert pull-down
    input wire logic ADC_START, // Conversion start
    input wire logic [1:0] ADC_CHANNEL, // Conversion channel
    input wire logic ADC_DONE // Conversion done
);
    logic [6:0] pins_prev_r;
    logic [2:0] stable_r;
    logic [9:0] gap_r;
    logic [7:0] st_exp;

    assign st_exp = {HSR_PINS.fet_on, HSR_PINS.gpio_level, 1'b0, !HSR_PINS.board_present_pin,
        !HSR_PINS.power_good_feedback, HSR_PINS.oc_cooldown, !HSR_PINS.undervoltage_input, HSR_PINS.overvoltage_input};

    // Pins need several quiet edges to cross the synchroniser
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pins_prev_r <= 7'h00;
            stable_r <= 3'h0;
            gap_r <= 10'h000;
        end
        else
        begin
            pins_prev_r <= HSR_PINS;
            stable_r <= (HSR_PINS != pins_prev_r) ? 3'h0 : (stable_r == 3'h7) ? 3'h7 : stable_r + 3'h1;
            gap_r <= ADC_DONE ? 10'h000 : (gap_r == 10'h3ff) ? gap_r : gap_r + 10'h001;
        end
    end

    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    property p_rd_valid;
        RD_VALID == $past(REG_REQ.rd);
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid not one cycle after read");
    property p_status_mirror;
        REG_REQ.rd && REG_REQ.addr[2:0] == 3'h2 && stable_r >= 3'h4 && HSR_PINS == pins_prev_r
            |=> (RD_DATA & 8'hdf) == ($past(st_exp) & 8'hdf);
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status bits differ from pins");
    property p_unmapped;
        REG_REQ.rd && REG_REQ.addr[2:0] inside {3'h0, 3'h1, 3'h7} |=> RD_DATA == 8'h00 && !RD_HIT;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not empty");
    property p_hit;
        REG_REQ.rd && REG_REQ.addr[2:0] inside {[3'h2:3'h6]} |=> RD_HIT;
    endproperty
    a_hit: assert property (p_hit) else $error("mapped read without hit");
    property p_fault_rsvd;
        REG_REQ.rd && REG_REQ.addr[2:0] == 3'h3 |=> RD_DATA[7:6] == 2'b00;
    endproperty
    a_fault_rsvd: assert property (p_fault_rsvd) else $error("fault log top bits not zero");
    property p_rd_hold;
        !REG_REQ.rd |=> $stable(RD_DATA) && $stable(RD_HIT);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_alert_off;
        ALERT_ENABLE == 6'h00 |=> !ALERT_OE;
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("alert with all enables clear");
    property p_alert_cause;
        $rose(ALERT_OE) |-> $past(ALERT_ENABLE) != 6'h00;
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert rose without enable");
    property p_start_gap;
        ADC_START |=> !ADC_START ##1 !ADC_START && gap_r >= 10'd401;
    endproperty
    a_start_gap: assert property (p_start_gap) else $error("conversion start too soon");
    property p_channel;
        ADC_CHANNEL != 2'h3 && ($stable(ADC_CHANNEL) || $past(ADC_DONE));
    endproperty
    a_channel: assert property (p_channel) else $error("channel moved without done");
    property p_test_write;
        REG_REQ.wr && TEST_MODE_BIT && REG_REQ.addr[2:0] inside {[3'h4:3'h6]} ##2
            REG_REQ.rd && !REG_REQ.wr && TEST_MODE_BIT && REG_REQ.addr[2:0] == $past(REG_REQ.addr[2:0], 2)
            |=> RD_DATA == $past(REG_REQ.wdata, 3);
    endproperty
    a_test_write: assert property (p_test_write) else $error("test mode write not read back");

    c_status: cover property (REG_REQ.rd && REG_REQ.addr[2:0] == 3'h2);
    c_alert: cover property ($rose(ALERT_OE));
    c_conv: cover property (ADC_START ##[1:60] ADC_DONE);
endmodule // hsr_regs_assertions

bind hsr_regs hsr_regs_assertions u_hsr_regs_assertions (.CLOCK(CLOCK), .RST_N(RST_N), .HSR_PINS(HSR_PINS),
    .REG_REQ(REG_REQ), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_HIT(RD_HIT), .TEST_MODE_BIT(TEST_MODE_BIT),
    .ALERT_ENABLE(ALERT_ENABLE), .ALERT_OE(ALERT_OE), .ADC_START(ADC_START), .ADC_CHANNEL(ADC_CHANNEL),
    .ADC_DONE(ADC_DONE));

// ---- tb/testbench.sv ----
// Self-checking bench of the live-insertion controller status register bank
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import hsr_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    hsr_pins_t pins = 7'h4c;
    hsr_reg_req_t req = '0;
    logic test_mode = 1'b0;
    logic [5:0] alert_en = 6'h00;
    logic [7:0] rd_data;
    logic rd_valid;
    logic rd_hit;
    logic alert_oe;
    logic adc_start;
    logic adc_done;
    logic [1:0] adc_ch;
    logic [7:0] adc_res;
    logic [31:0] sense_uv = 32'h0;
    logic [31:0] out_mv = 32'h0;
    logic [31:0] aux_mv = 32'h0;
    integer seed = 32'hb51fd850;
    int err_count = 0;
    int n_checks = 0;
    logic [2:0] unm [3] = '{3'h0, 3'h1, 3'h7};
    // Each event flips one pin from a quiet state
    hsr_pins_t pre [6] = '{7'h4c, 7'h5c, 7'h4c, 7'h4c, 7'h4c, 7'h4c};
    hsr_pins_t post [6] = '{7'h5c, 7'h4c, 7'h44, 7'h48, 7'h4e, 7'h4d};
    logic [7:0] fexp [6] = '{8'h10, 8'h10, 8'h08, 8'h02, 8'h01, 8'h04};

    hsr_regs u_hsr_regs (.CLOCK(clock), .RST_N(rst_n), .HSR_PINS(pins), .REG_REQ(req), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .RD_HIT(rd_hit), .TEST_MODE_BIT(test_mode), .ALERT_ENABLE(alert_en), .ALERT_O(),
        .ALERT_OE(alert_oe), .ADC_START(adc_start), .ADC_CHANNEL(adc_ch), .ADC_DONE(adc_done), .ADC_RESULT(adc_res));
    hsr_adc_model u_hsr_adc_model (.clock(clock), .rst_n(rst_n), .adc_start(adc_start), .adc_channel(adc_ch),
        .adc_done(adc_done), .adc_result(adc_res), .sense_uv(sense_uv), .out_mv(out_mv), .aux_mv(aux_mv));

    initial
    begin
        forever #12.5 clock = ~clock;
    end

    function automatic logic [7:0] to_code(input logic [31:0] v, input logic [31:0] lsb);
        return (v / lsb > 32'hff) ? 8'hff : 8'(v / lsb);
    endfunction

    function automatic logic [7:0] st_exp(input hsr_pins_t p, input logic [7:0] sense);
        return {p.fet_on, p.gpio_level, sense > SHORT_THRESH_CODE && !p.fet_on, !p.board_present_pin,
            !p.power_good_feedback, p.oc_cooldown, !p.undervoltage_input, p.overvoltage_input};
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Called at a falling edge; strobe lasts one rising edge, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clock);
        req.wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clock);
        req.rd = 1'b0;
        chk("rd_valid", 8'h01, {7'h0, rd_valid});
        chk(what, exp, rd_data);
        chk("rd_hit", {7'h0, a[2:0] inside {[3'h2:3'h6]}}, {7'h0, rd_hit});
        @(negedge clock);
    endtask

    task automatic test_done();
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        logic [7:0] a;
        logic [7:0] smp [3];
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
        rdchk("fault_log", 8'h03, 8'h00);
        for (int i = 0; i < 12; i++)
        begin
            pins = 7'($random(seed));
            a = {5'($random(seed)), 3'h2};
            wr(a, 8'($random(seed)));
            repeat (5) @(negedge clock);
            rdchk("system_status", a, st_exp(pins, 8'h00));
            rdchk("unmapped", {5'($random(seed)), unm[i % 3]}, 8'h00);
        end
        for (int i = 0; i < 6; i++)
        begin
            pins = pre[i];
            alert_en = 6'($random(seed));
            repeat (5) @(negedge clock);
            wr(8'h03, 8'h00);
            rdchk("fault_log", 8'h03, 8'h00);
            chk("alert_oe", 8'h00, {7'h0, alert_oe});
            pins = post[i];
            repeat (5) @(negedge clock);
            rdchk("fault_log", 8'h03, fexp[i]);
            chk("alert_oe", {7'h0, |(fexp[i][5:0] & alert_en)}, {7'h0, alert_oe});
            pins = pre[i];
            repeat (5) @(negedge clock);
            rdchk("fault_log", 8'h03, fexp[i]);
        end
        alert_en = 6'h00;
        pins = 7'h0c;
        test_mode = 1'b1;
        repeat (5) @(negedge clock);
        wr(8'h03, 8'h00);
        wr(8'h04, 8'h07);
        repeat (5) @(negedge clock);
        rdchk("system_status", 8'h02, st_exp(pins, 8'h07));
        rdchk("fault_log", 8'h03, 8'h20);
        wr(8'h04, 8'h06);
        repeat (5) @(negedge clock);
        rdchk("system_status", 8'h02, st_exp(pins, 8'h06));
        rdchk("fault_log", 8'h03, 8'h20);
        wr(8'hfb, 8'hff);
        rdchk("fault_log", 8'h03, 8'h3f);
        for (int i = 0; i < 3; i++)
        begin
            smp[i] = 8'($random(seed));
            wr(8'h04 + 8'(i), smp[i]);
            rdchk("sample", 8'h04 + 8'(i), smp[i]);
        end
        // Held through a span longer than one conversion interval
        repeat (500) @(negedge clock);
        test_mode = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h04 + 8'(i), ~smp[i]);
            rdchk("sample", 8'h04 + 8'(i), smp[i]);
        end
        for (int r = 0; r < 2; r++)
        begin
            sense_uv = (r == 0) ? 32'($unsigned($random(seed)) % SENSE_FULL_SCALE_UV) : 32'(SENSE_FULL_SCALE_UV - 1);
            out_mv = (r == 0) ? 32'($unsigned($random(seed)) % OUTPUT_FULL_SCALE_MV) : 32'(OUTPUT_FULL_SCALE_MV - 1);
            aux_mv = (r == 0) ? 32'($unsigned($random(seed)) % AUX_FULL_SCALE_MV) : 32'(AUX_FULL_SCALE_MV - 1);
            repeat (1400) @(negedge clock);
            rdchk("current_sense_sample", 8'h04, to_code(sense_uv, SENSE_LSB_UV));
            rdchk("output_voltage_sample", 8'h05, to_code(out_mv, OUTPUT_LSB_MV));
            rdchk("aux_input_sample", 8'h06, to_code(aux_mv, AUX_LSB_MV));
        end
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        test_done();
    end
endmodule // testbench
